// >>> smk_pkg.sv
// Package for the security mode and key manager: modes, register map, field layouts.
package smk_pkg;

  // Security modes reported to software, decoded from the monitor state.
  typedef enum logic [1:0] {
    SMK_MODE_NONSECURE = 2'b00,
    SMK_MODE_SECURE    = 2'b01,
    SMK_MODE_TRUSTED   = 2'b10,
    SMK_MODE_FAIL      = 2'b11
  } smk_mode_t;

  // Monitor states as presented on the monitor state input.
  typedef enum logic [2:0] {
    SMK_MON_INIT      = 3'b000,
    SMK_MON_CHECK     = 3'b001,
    SMK_MON_TRUSTED   = 3'b010,
    SMK_MON_SECURE    = 3'b011,
    SMK_MON_NONSECURE = 3'b100,
    SMK_MON_FAIL      = 3'b101
  } smk_mon_t;

  // Job interface from the descriptor engine: start and done pulses.
  typedef struct packed {
    logic start;
    logic done;
  } smk_job_req_t;

  // Job completion report to the descriptor engine.
  typedef struct packed {
    logic done;
    logic error;
  } smk_job_rsp_t;

  localparam int          SMK_KEY_W      = 256;
  localparam int          SMK_NUM_KEYS   = 3;
  localparam int          SMK_WORDS      = 8;
  localparam int          SMK_MLEN_W     = 2;

  // Register byte offsets.
  localparam logic [11:0] SMK_STATUS_OFF = 12'h000;
  localparam logic [11:0] SMK_CTRL_OFF   = 12'h004;
  localparam logic [11:0] SMK_KEY_OFF    = 12'h100;
  localparam logic [11:0] SMK_KEY_END    = 12'h160;

  // Status field positions.
  localparam int          SMK_ST_MODE_LSB = 0;
  localparam int          SMK_ST_LOCK_BIT = 4;
  localparam int          SMK_ST_BUSY_BIT = 5;
  localparam int          SMK_ST_ALRM_BIT = 6;

  // Control field positions.
  localparam int          SMK_CT_LOCK_BIT = 0;
  localparam int          SMK_CT_ALRM_BIT = 1;

  localparam logic [31:0] SMK_ZERO_WORD   = 32'h0000_0000;

  // Derivation inputs; one per mode, with fail sharing the non-secure input and blob key.
  localparam logic [255:0] SMK_DIV_TRUSTED   = {8{32'h5452_5553}};
  localparam logic [255:0] SMK_DIV_SECURE    = {8{32'h5345_4355}};
  localparam logic [255:0] SMK_DIV_NONSECURE = {8{32'h4e53_4543}};
  // Hardwired test key for known-answer blob testing; value arbitrary.
  localparam logic [255:0] SMK_TEST_KEY      = {8{32'h0123_4567}};

endpackage : smk_pkg

// >>> smk_key_manager.sv
// Security mode tracking, volatile key store and blob key derivation with APB access.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] Status register shows current security mode.
// [RL2] Mode follows monitor state only.
// [RL3] Alarm output raised toward the monitor.
// [RL4] Three 256-bit volatile key registers.
// [RL5] Keys zeroized on entering fail mode.
// [RL6] Boot software generates keys after RNG.
// [RL7] Job and trusted wrap keys per descriptor.
// [RL8] Signing key used for trusted descriptors.
// [RL9] Keys usable in trusted, secure, non-secure.
// [RL10] Non-secure key access until lock applied.
// [RL11] Trusted/secure blob keys from master key.
// [RL12] Non-secure/fail blob keys from test key.
// [RL13] Distinct derivation inputs per mode; fail reuses the non-secure input.
// [RL14] Derived key serves blob operations.
// [RL15] Fail entry clears all sensitive state.
// [RL16] Running job finishes with error on fail.
// [RL17] Software leaves fail via monitor only.
// [RL18] No return from fail to secure/trusted.
// [RL19] Lock sticky until reset; keys reset zero.
module smk_key_manager (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [2:0]            mon_state,
  input  wire logic [255:0]          master_key,
  input  wire logic                  alarm_detect,
  output logic                       alarm_out,
  output logic      [1:0]            current_mode_field,
  input  wire logic [1:0]            key_sel,
  input  wire logic                  trusted_desc,
  output logic      [255:0]          wrap_key,
  output logic      [255:0]          blob_wrap_key,
  output logic                       sensitive_clear,
  input  wire smk_pkg::smk_job_req_t job_req,
  output smk_pkg::smk_job_rsp_t      job_rsp
);
  import smk_pkg::*;

  // ****************************************
  // Mode decode
  // ****************************************
  logic [2:0]   mon_s1_ff;
  logic [2:0]   mon_s2_ff;
  logic         alm_s1_ff;
  logic         alm_s2_ff;
  smk_mode_t    mode_ff;
  smk_mode_t    nxt_mode;
  logic         fail_entry;
  logic         hw_fail_ff;
  // Job tracking flops are declared here because the status read below uses job_busy_ff.
  logic         job_busy_ff;
  logic         job_fail_ff;

  // Monitor state is external; two flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_s1_ff <= 3'h0;
      mon_s2_ff <= 3'h0;
      alm_s1_ff <= 1'b0;
      alm_s2_ff <= 1'b0;
    end else begin
      mon_s1_ff <= mon_state;
      mon_s2_ff <= mon_s1_ff;
      alm_s1_ff <= alarm_detect;
      alm_s2_ff <= alm_s1_ff;
    end
  end

  // The mode is decoded from monitor state except where fail or the sticky flag blocks it; init and check act as non-secure.
  always_comb begin
    case (smk_mon_t'(mon_s2_ff))                                   // RL2
      SMK_MON_TRUSTED:   nxt_mode = SMK_MODE_TRUSTED;
      SMK_MON_SECURE:    nxt_mode = SMK_MODE_SECURE;
      SMK_MON_FAIL:      nxt_mode = SMK_MODE_FAIL;
      default:           nxt_mode = SMK_MODE_NONSECURE;
    endcase
    // Once failed, a claimed secure or trusted state is not honoured.
    if (mode_ff == SMK_MODE_FAIL && (nxt_mode == SMK_MODE_TRUSTED || nxt_mode == SMK_MODE_SECURE)) begin
      nxt_mode = SMK_MODE_FAIL;                                     // RL18
    end
  end

  // A sticky flag blocks secure modes after fail or non-secure until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_fail_ff <= 1'b0;
    end else if (mode_ff == SMK_MODE_FAIL || (mode_ff == SMK_MODE_NONSECURE && mon_s2_ff == SMK_MON_NONSECURE)) begin
      hw_fail_ff <= 1'b1;                                           // RL18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= SMK_MODE_NONSECURE;
    end else if (hw_fail_ff && (nxt_mode == SMK_MODE_TRUSTED || nxt_mode == SMK_MODE_SECURE)) begin
      mode_ff <= (mode_ff == SMK_MODE_FAIL) ? SMK_MODE_FAIL : SMK_MODE_NONSECURE; // RL18
    end else begin
      mode_ff <= nxt_mode;                                          // RL2
    end
  end

  assign fail_entry = (nxt_mode == SMK_MODE_FAIL) && (mode_ff != SMK_MODE_FAIL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_mode_field <= 2'b00;
      sensitive_clear    <= 1'b0;
    end else begin
      current_mode_field <= mode_ff;                                // RL1
      // One pulse tells the engines to wipe context, math, FIFOs and buffers.
      sensitive_clear    <= fail_entry;                             // RL15
    end
  end

  // ****************************************
  // Register access and keys
  // ****************************************
  logic [255:0] key_ff [SMK_NUM_KEYS];                              // RL4
  logic         lock_ff;
  logic         sw_alarm_ff;
  logic         apb_acc;
  logic         key_hit;
  logic [1:0]   key_idx;
  logic [2:0]   key_word;
  logic         key_open;
  logic [31:0]  rd_val;
  logic         rd_err;

  // Key window decode: 8 words per key, 3 keys from the base.
  function automatic logic in_key(input logic [11:0] a);
    return (a >= SMK_KEY_OFF) && (a < SMK_KEY_END) && (a[1:0] == 2'b00);
  endfunction

  assign apb_acc  = psel && penable && !pready;
  assign key_hit  = in_key(paddr);
  assign key_idx  = paddr[6:5] - SMK_KEY_OFF[6:5];
  assign key_word = paddr[4:2];
  // Keys are reachable only in non-secure mode and before the lock.
  assign key_open = (mode_ff == SMK_MODE_NONSECURE) && !lock_ff;    // RL10

  always_comb begin
    rd_val = SMK_ZERO_WORD;
    rd_err = 1'b0;
    if (paddr == SMK_STATUS_OFF) begin
      rd_val[SMK_ST_MODE_LSB +: 2] = mode_ff;                       // RL1
      rd_val[SMK_ST_LOCK_BIT]      = lock_ff;
      rd_val[SMK_ST_BUSY_BIT]      = job_busy_ff;
      rd_val[SMK_ST_ALRM_BIT]      = alarm_out;
    end else if (paddr == SMK_CTRL_OFF) begin
      rd_val[SMK_CT_LOCK_BIT] = lock_ff;
      rd_val[SMK_CT_ALRM_BIT] = sw_alarm_ff;
    end else if (key_hit && key_open) begin
      rd_val = key_ff[key_idx][key_word*32 +: 32];                  // RL10
    end else begin
      rd_err = 1'b1;
    end
  end

  // Single-wait-state APB slave: ready one cycle into the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= SMK_ZERO_WORD;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc && rd_err;
      prdata  <= (apb_acc && !pwrite) ? rd_val : SMK_ZERO_WORD;
    end
  end

  // Lock is set by software and only reset clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff     <= 1'b0;                                          // RL19
      sw_alarm_ff <= 1'b0;
    end else if (pready && pwrite && paddr == SMK_CTRL_OFF) begin
      lock_ff     <= lock_ff | pwdata[SMK_CT_LOCK_BIT];             // RL19
      sw_alarm_ff <= pwdata[SMK_CT_ALRM_BIT];
    end
  end

  // Key store; fail entry beats any write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < SMK_NUM_KEYS; k++) key_ff[k] <= '0;       // RL19
    end else if (fail_entry || mode_ff == SMK_MODE_FAIL) begin
      for (int k = 0; k < SMK_NUM_KEYS; k++) key_ff[k] <= '0;       // RL5
    end else if (pready && pwrite && key_hit && key_open && !rd_err) begin
      key_ff[key_idx][key_word*32 +: 32] <= pwdata;                 // RL10
    end
  end

  // ****************************************
  // Key selection and blob derivation
  // ****************************************
  // Trusted descriptors wrap with their own key; key_sel 2 picks the signer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_key <= '0;
    end else if (mode_ff == SMK_MODE_FAIL) begin
      wrap_key <= '0;
    end else if (key_sel == 2'd2) begin
      wrap_key <= key_ff[2];                                        // RL8
    end else begin
      wrap_key <= trusted_desc ? key_ff[1] : key_ff[0];             // RL7 RL9
    end
  end

  // The derivation mixes the source with a per-mode input; a plain XOR keeps it cheap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blob_wrap_key <= '0;
    end else begin
      case (mode_ff)
        SMK_MODE_TRUSTED: blob_wrap_key <= master_key ^ SMK_DIV_TRUSTED;   // RL11 RL13 RL14
        SMK_MODE_SECURE:  blob_wrap_key <= master_key ^ SMK_DIV_SECURE;    // RL11 RL13
        default:          blob_wrap_key <= SMK_TEST_KEY ^ SMK_DIV_NONSECURE; // RL12
      endcase
    end
  end

  // ****************************************
  // Alarm and job completion
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= alm_s2_ff | sw_alarm_ff;                         // RL3
    end
  end

  // A job that sees fail keeps running but its done carries an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_busy_ff <= 1'b0;
      job_fail_ff <= 1'b0;
      job_rsp     <= '0;
    end else begin
      job_rsp.done  <= job_busy_ff && job_req.done;
      // A fail entry in the very cycle of done or start still marks the job as failed.
      job_rsp.error <= job_busy_ff && job_req.done && (job_fail_ff || mode_ff == SMK_MODE_FAIL || fail_entry); // RL16
      if (job_req.start) begin
        job_busy_ff <= 1'b1;
        job_fail_ff <= (mode_ff == SMK_MODE_FAIL) || fail_entry;    // RL16
      end else if (job_req.done) begin
        job_busy_ff <= 1'b0;
        job_fail_ff <= 1'b0;
      end else if (job_busy_ff && fail_entry) begin
        job_fail_ff <= 1'b1;                                        // RL16
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence fail_seen_s;
    nxt_mode == SMK_MODE_FAIL && mode_ff != SMK_MODE_FAIL;
  endsequence

  keys_zero_fail_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    fail_seen_s |=> (key_ff[0] == '0 && key_ff[1] == '0 && key_ff[2] == '0))
    else $error("keys not zeroized after fail entry");
  clear_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    fail_seen_s |=> sensitive_clear)
    else $error("sensitive clear missing on fail entry");
  mode_report_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    current_mode_field == $past(mode_ff))
    else $error("reported mode lags wrongly");
  no_return_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    mode_ff == SMK_MODE_FAIL |=> mode_ff == SMK_MODE_FAIL || mode_ff == SMK_MODE_NONSECURE)
    else $error("left fail to secure or trusted");
  lock_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    lock_ff |=> lock_ff)
    else $error("lock dropped without reset");
  alarm_path_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    alm_s2_ff |=> alarm_out)
    else $error("alarm not forwarded");
  blob_test_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    mode_ff == SMK_MODE_FAIL ##1 mode_ff == SMK_MODE_FAIL |-> blob_wrap_key == (SMK_TEST_KEY ^ SMK_DIV_NONSECURE))
    else $error("blob key not from test key in fail");
  blob_master_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    mode_ff == SMK_MODE_TRUSTED |=> blob_wrap_key == ($past(master_key) ^ SMK_DIV_TRUSTED))
    else $error("trusted blob key not from master key");
  job_error_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    job_busy_ff && job_req.done && mode_ff == SMK_MODE_FAIL |=> job_rsp.done && job_rsp.error)
    else $error("job in fail finished without error");
  locked_refuse_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    apb_acc && key_hit && lock_ff |=> pready && pslverr)
    else $error("locked key access not refused");

endmodule // smk_key_manager
`default_nettype wire

// >>> smk_monitor_model.sv
// Behavioural model of the security state monitor that drives the key manager.
`timescale 1ns/1ps
`default_nettype none
module smk_monitor_model #(
  parameter logic [255:0] MKEY = {8{32'h1357_9bdf}}  // Arbitrary master key value.
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [2:0]   req_state,
  input  wire logic         req_go,
  input  wire logic         rogue,
  input  wire logic         lockout,
  input  wire logic         alarm_out,
  output logic      [2:0]   mon_state,
  output logic      [255:0] master_key
);
  import smk_pkg::*;
  // ************************************************************
  // Security state machine
  // ************************************************************
  logic [2:0] state_ff;

  // The master key is non-volatile, so it is a constant here.
  assign master_key = MKEY;
  assign mon_state  = state_ff;

  // An alarm beats any command; fail is left only toward non-secure.
  // The rogue input lets a scenario present an illegal state on purpose.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SMK_MON_INIT;
    end else if (alarm_out) begin
      state_ff <= SMK_MON_FAIL;
    end else if (req_go && (rogue || state_ff != SMK_MON_FAIL ||
                 (req_state == SMK_MON_NONSECURE && !lockout))) begin
      state_ff <= req_state;
    end
  end
endmodule  // smk_monitor_model
`default_nettype wire

// >>> smk_key_manager_bench.sv
// Self-checking bench for the security mode and key manager.
`timescale 1ns/1ps
`default_nettype none
module smk_key_manager_bench;
  import smk_pkg::*;
  typedef struct packed {
    smk_mon_t     mon;
    smk_mode_t    mode;
    logic [255:0] blob;
  } smk_row_t;
  localparam logic [255:0] MKEY = {8{32'h1357_9bdf}};  // Arbitrary master key value.
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
  logic         alarm_detect, alarm_out, trusted_desc, sensitive_clear;
  logic         req_go, rogue, lockout;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd_q;
  logic [2:0]   mon_state, req_state;
  logic [1:0]   current_mode_field, key_sel;
  logic [255:0] master_key, wrap_key, blob_wrap_key;
  smk_job_req_t job_req;
  smk_job_rsp_t job_rsp;
  int           miscompares, cmp_count;
  smk_row_t     rows [4] = '{
    '{SMK_MON_INIT, SMK_MODE_NONSECURE, SMK_TEST_KEY ^ SMK_DIV_NONSECURE},
    '{SMK_MON_CHECK, SMK_MODE_NONSECURE, SMK_TEST_KEY ^ SMK_DIV_NONSECURE},
    '{SMK_MON_TRUSTED, SMK_MODE_TRUSTED, MKEY ^ SMK_DIV_TRUSTED},
    '{SMK_MON_SECURE, SMK_MODE_SECURE, MKEY ^ SMK_DIV_SECURE}};

  smk_key_manager i_smk_key_manager (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mon_state(mon_state), .master_key(master_key), .alarm_detect(alarm_detect), .alarm_out(alarm_out),
    .current_mode_field(current_mode_field), .key_sel(key_sel), .trusted_desc(trusted_desc),
    .wrap_key(wrap_key), .blob_wrap_key(blob_wrap_key), .sensitive_clear(sensitive_clear),
    .job_req(job_req), .job_rsp(job_rsp));
  smk_monitor_model #(.MKEY(MKEY)) i_smk_monitor_model (.pclk(pclk), .presetn(presetn),
    .req_state(req_state), .req_go(req_go), .rogue(rogue), .lockout(lockout), .alarm_out(alarm_out),
    .mon_state(mon_state), .master_key(master_key));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string n, input logic [255:0] s, input logic [255:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic acc(input string n, input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    rd_q = 'x;
    rd_e = 'x;
    // Only the watchdog ends a wait for an answer that never comes.
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({n, " data"}, rd_q, x);
    chk({n, " err"}, rd_e, xe);
  endtask

  // The mode follows the monitor four cycles later; six leaves margin.
  task automatic set_mon(input logic [2:0] s, input logic r);
    @(posedge pclk);
    req_state <= s;
    req_go <= 1'b1;
    rogue <= r;
    @(posedge pclk);
    req_go <= 1'b0;
    rogue <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and stimulus
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The whole run takes well under a thousand cycles.
  initial begin
    #200_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, alarm_detect, trusted_desc, req_go, rogue, lockout} = '0;
    {paddr, pwdata, key_sel, req_state, job_req} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      set_mon(rows[i].mon, 1'b0);
      chk("mode", current_mode_field, rows[i].mode);
      chk("blob key", blob_wrap_key, rows[i].blob);
      chk("wrap key reset", wrap_key, '0);
      acc("status", 1'b0, SMK_STATUS_OFF, '0, 32'(rows[i].mode), 1'b0);
    end
    acc("key in secure", 1'b0, SMK_KEY_OFF, '0, '0, 1'b1);
    acc("unmapped", 1'b0, 12'h008, '0, '0, 1'b1);
    set_mon(SMK_MON_NONSECURE, 1'b0);
    chk("nonsecure blob", blob_wrap_key, SMK_TEST_KEY ^ SMK_DIV_NONSECURE);
    for (int k = 0; k < 3; k++) begin
      acc("key wr", 1'b1, SMK_KEY_OFF + 12'(k * 32), 32'ha5a5_0000 + 32'(k), '0, 1'b0);
      acc("key rd", 1'b0, SMK_KEY_OFF + 12'(k * 32), '0, 32'ha5a5_0000 + 32'(k), 1'b0);
      key_sel <= (k == 2) ? 2'd2 : 2'd0;
      trusted_desc <= (k == 1);
      repeat (3) @(posedge pclk);
      chk("wrap key", wrap_key, {224'h0, 32'ha5a5_0000 + 32'(k)});
    end
    set_mon(SMK_MON_SECURE, 1'b1);
    chk("no return to secure", current_mode_field, SMK_MODE_NONSECURE);
    acc("lock", 1'b1, SMK_CTRL_OFF, 32'h0000_0001, '0, 1'b0);
    acc("unlock try", 1'b1, SMK_CTRL_OFF, 32'h0000_0000, '0, 1'b0);
    acc("status lock", 1'b0, SMK_STATUS_OFF, '0, 32'h0000_0010, 1'b0);
    acc("locked wr", 1'b1, SMK_KEY_OFF + 12'h040, 32'hffff_ffff, '0, 1'b1);
    acc("locked rd", 1'b0, SMK_KEY_OFF + 12'h040, '0, '0, 1'b1);
    chk("key kept", wrap_key, {224'h0, 32'ha5a5_0002});
    job_req <= '{1'b1, 1'b0};
    @(posedge pclk);
    job_req <= '0;
    acc("sw alarm", 1'b1, SMK_CTRL_OFF, 32'h0000_0003, '0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("alarm out", alarm_out, 1'b1);
    for (int i = 0; i < 20 && sensitive_clear !== 1'b1; i++) @(posedge pclk);
    chk("clear pulse", sensitive_clear, 1'b1);
    repeat (3) @(posedge pclk);
    chk("keys zeroized", wrap_key, '0);
    chk("fail mode", current_mode_field, SMK_MODE_FAIL);
    job_req <= '{1'b0, 1'b1};
    @(posedge pclk);
    job_req <= '0;
    for (int i = 0; i < 8 && job_rsp.done !== 1'b1; i++) @(posedge pclk);
    chk("job error", {job_rsp.done, job_rsp.error}, 2'b11);
    acc("alarm off", 1'b1, SMK_CTRL_OFF, 32'h0000_0001, '0, 1'b0);
    set_mon(SMK_MON_TRUSTED, 1'b1);
    chk("no return to trusted", current_mode_field, SMK_MODE_FAIL);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    acc("status after reset", 1'b0, SMK_STATUS_OFF, '0, '0, 1'b0);
    chk("keys after reset", wrap_key, '0);
    alarm_detect <= 1'b1;
    for (int i = 0; i < 8 && alarm_out !== 1'b1; i++) @(posedge pclk);
    chk("alarm pin", alarm_out, 1'b1);
    report_and_stop();
  end
endmodule  // smk_key_manager_bench
`default_nettype wire
